/* File: rtl/rwdt_pkg.sv */
/*
  Shared constants of the runaway watchdog: register map, field layout,
  key codes, reset values, timing counts and the CPU-end state set.
  Assumes an 8-bit register path and a 20 MHz system clock.
*/
package rwdt_pkg;
  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int            ADDR_W        = 16;
  localparam int            DATA_W        = 8;
  localparam logic [15:0]   ADDR_MODE     = 16'h0300;
  localparam logic [15:0]   ADDR_KEY_CMD  = 16'h0301;

  // ------------------------------------------------------------------
  // watchdog_mode fields and reset values
  // ------------------------------------------------------------------
  localparam int            BIT_ENABLE    = 7;
  localparam int            BIT_TP_HI     = 6;
  localparam int            BIT_TP_LO     = 5;
  localparam int            BIT_PSL_RUN   = 2;
  localparam int            BIT_RST_CONN  = 1;
  localparam logic          RST_ENABLE    = 1'b1;
  localparam logic [1:0]    RST_TP        = 2'h0;
  localparam logic          RST_PSL_RUN   = 1'b0;
  localparam logic          RST_RST_CONN  = 1'b0;

  // ------------------------------------------------------------------
  // Key codes written to watchdog_key_command
  // ------------------------------------------------------------------
  localparam logic [7:0]    KEY_CLEAR     = 8'h4E;
  localparam logic [7:0]    KEY_DISABLE   = 8'hB1;

  // ------------------------------------------------------------------
  // Counter and timing
  // ------------------------------------------------------------------
  localparam int            CNT_W         = 22;
  localparam int            TAP_00        = 15;
  localparam int            TAP_01        = 17;
  localparam int            TAP_10        = 19;
  localparam int            TAP_11        = 21;
  localparam int            SYS_CLK_HZ    = 20_000_000;
  // One state is two prescaled periods, equal to one system clock
  localparam int            CYC_PER_STATE = 1;
  localparam int            RST_STATES    = 22;
  localparam int            RST_CYCLES    = RST_STATES * CYC_PER_STATE;
  localparam int            RST_CNT_W     = 8;

  // ------------------------------------------------------------------
  // CPU-end access sequencer
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    RWDT_IDLE   = 3'b001,
    RWDT_ACCESS = 3'b010,
    RWDT_WAIT   = 3'b100
  } rwdt_state_e;
endpackage : rwdt_pkg

/* File: rtl/rwdt_if.sv */
/*
  Link between the CPU end and the watchdog device: a one-cycle
  register strobe path with read return, and the NMI request.
  Assumes both ends share i_sys_clk.
*/
`timescale 1ns/100ps
interface rwdt_if;
  import rwdt_pkg::*;
  logic              wr;
  logic              rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              rvalid;
  logic              runaway_nmi_request;

  modport device (
    input  wr, rd, addr, wdata,
    output rdata, rvalid, runaway_nmi_request
  );
  modport cpu (
    output wr, rd, addr, wdata,
    input  rdata, rvalid, runaway_nmi_request
  );
endinterface : rwdt_if

/* File: rtl/rwdt_device.sv */
/*
  Runaway watchdog device: 22-stage counter, tap select, two-step
  disable, key-code clear, NMI pulse and forced internal reset.
  Assumes standby-mode levels come from logic on the same clock and
  that the CPU end drives single-cycle strobes.
*/
`timescale 1ns/100ps
// Operation
// - Tap overflow raises non-maskable interrupt request
// - Reset-connect bit makes overflow force reset
// - 22-stage up-counter on system clock
// - Two-bit field picks tap 15,17,19,21
// - Detection-time field resets to 00
// - Enable bit resets to 1, counting
// - Disable needs enable cleared then key B1
// - Enable bit set alone re-enables watchdog
// - Key 4E clears counter, counting resumes
// - Software clears counter before detection time
// - Reset-connect bit resets to 0
// - Counter stops in light-sleep or full-stop
// - Counter keeps running during bus release
// - Partial-sleep runs only with run bit set
// - Forced reset lasts 22 to 29 states
// - Software clears, drops enable, then disables
// - Software disables before changing settings
module rwdt_device (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_reset,
  rwdt_if.device                           bus,
  input  wire logic                        i_light_sleep_mode,
  input  wire logic                        i_full_stop_mode,
  input  wire logic                        i_partial_sleep_mode,
  input  wire logic                        i_bus_release_ack_n,
  output logic                             o_internal_reset,
  output logic [rwdt_pkg::CNT_W-1:0]       o_count
);
  import rwdt_pkg::*;

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic                 runaway_timer_enable;
  logic [1:0]           detect_time_select;
  logic                 partial_sleep_run;
  logic                 overflow_reset_connect;
  logic                 disabled;
  logic [CNT_W-1:0]     count;
  logic [RST_CNT_W-1:0] rst_left;
  logic                 nmi_q;
  logic [DATA_W-1:0]    rdata_q;
  logic                 rvalid_q;

  logic                 wr_mode;
  logic                 wr_key;
  logic                 key_clear;
  logic                 key_disable;
  logic                 run;
  logic                 tap_hit;

  // ------------------------------------------------------------------
  // Register and key decode
  // ------------------------------------------------------------------
  assign wr_mode     = bus.wr && (bus.addr == ADDR_MODE);
  assign wr_key      = bus.wr && (bus.addr == ADDR_KEY_CMD);
  // Any other key value is decoded as nothing at all
  assign key_clear   = wr_key && (bus.wdata == KEY_CLEAR);
  assign key_disable = wr_key && (bus.wdata == KEY_DISABLE);

  // ------------------------------------------------------------------
  // Mode register
  // ------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      runaway_timer_enable   <= RST_ENABLE;
      detect_time_select     <= RST_TP;
      partial_sleep_run      <= RST_PSL_RUN;
      overflow_reset_connect <= RST_RST_CONN;
    end else if (wr_mode) begin
      runaway_timer_enable   <= bus.wdata[BIT_ENABLE];
      detect_time_select     <= bus.wdata[BIT_TP_HI:BIT_TP_LO];
      partial_sleep_run      <= bus.wdata[BIT_PSL_RUN];
      overflow_reset_connect <= bus.wdata[BIT_RST_CONN];
    end
  end

  // ------------------------------------------------------------------
  // Disable state: two steps in, one step out
  // ------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      disabled <= 1'b0;
    // Enable write wins over a same-cycle key, so a runaway cannot lock it off
    end else if (wr_mode && bus.wdata[BIT_ENABLE]) begin
      disabled <= 1'b0;
    end else if (key_disable && !runaway_timer_enable) begin
      disabled <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Binary counter
  // ------------------------------------------------------------------
  // Bus release does not pause counting, so the acknowledge is unused
  // Standby levels are same-clock logic, so they need no synchroniser
  always_comb begin
    run = !disabled && !i_light_sleep_mode && !i_full_stop_mode
          && !(i_partial_sleep_mode && !partial_sleep_run);
  end

  // ------------------------------------------------------------------
  // Tap select
  // ------------------------------------------------------------------
  always_comb begin
    case (detect_time_select)
      2'h0:    tap_hit = &count[TAP_00-1:0];
      2'h1:    tap_hit = &count[TAP_01-1:0];
      2'h2:    tap_hit = &count[TAP_10-1:0];
      default: tap_hit = &count[TAP_11-1:0];
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset || o_internal_reset || key_clear) begin
      count <= '0;
    end else if (run) begin
      count <= count + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Overflow: NMI pulse and forced reset
  // ------------------------------------------------------------------
  // A clear key in the overflow cycle wins; the count never got there
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      nmi_q <= 1'b0;
    end else begin
      nmi_q <= run && tap_hit && !key_clear && !o_internal_reset;
    end
  end

  // ------------------------------------------------------------------
  // Forced reset
  // ------------------------------------------------------------------
  // Length sits at the low end of the allowed range to shorten downtime
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rst_left <= '0;
    end else if (nmi_q && overflow_reset_connect) begin
      rst_left <= RST_CNT_W'(RST_CYCLES);
    end else if (rst_left != '0) begin
      rst_left <= rst_left - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_internal_reset <= 1'b0;
    end else begin
      // Drives only the internal reset net; the pin level is untouched
      o_internal_reset <= (nmi_q && overflow_reset_connect)
                          || (rst_left > RST_CNT_W'(1));
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= bus.rd;
    end
  end

  // Unused mode bits read as zero
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdata_q  <= '0;
    end else begin
      if (bus.rd && bus.addr == ADDR_MODE) begin
        rdata_q <= '0;
        rdata_q[BIT_ENABLE]            <= runaway_timer_enable;
        rdata_q[BIT_TP_HI:BIT_TP_LO]   <= detect_time_select;
        rdata_q[BIT_PSL_RUN]           <= partial_sleep_run;
        rdata_q[BIT_RST_CONN]          <= overflow_reset_connect;
      end else begin
        // Key register is write-only; unmapped reads return zero
        rdata_q <= '0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_count <= '0;
    end else begin
      o_count <= count;
    end
  end

  assign bus.rdata               = rdata_q;
  assign bus.rvalid              = rvalid_q;
  assign bus.runaway_nmi_request = nmi_q;
endmodule : rwdt_device

/* File: rtl/rwdt_cpu.sv */
/*
  CPU end of the watchdog link: turns one user command into a single
  register strobe, returns read data and flags the NMI request.
  Assumes the user holds a command until o_cmd_done.
*/
`timescale 1ns/100ps
module rwdt_cpu (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_reset,
  rwdt_if.cpu                                bus,
  input  wire logic                          i_cmd_valid,
  input  wire logic                          i_cmd_write,
  input  wire logic [rwdt_pkg::ADDR_W-1:0]   i_cmd_addr,
  input  wire logic [rwdt_pkg::DATA_W-1:0]   i_cmd_wdata,
  output logic      [rwdt_pkg::DATA_W-1:0]   o_cmd_rdata,
  output logic                               o_cmd_done,
  output logic                               o_nmi
);
  import rwdt_pkg::*;

  rwdt_state_e       state;
  logic              wr_q;
  logic              rd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;

  // ------------------------------------------------------------------
  // Access sequencer
  // ------------------------------------------------------------------
  // Software ordering of keys and settings is the user's job
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state      <= RWDT_IDLE;
      wr_q       <= 1'b0;
      rd_q       <= 1'b0;
      addr_q     <= '0;
      wdata_q    <= '0;
      o_cmd_done <= 1'b0;
    end else begin
      wr_q       <= 1'b0;
      rd_q       <= 1'b0;
      o_cmd_done <= 1'b0;
      case (state)
        RWDT_IDLE: begin
          // Skip the done cycle: the user only sees done after this edge
          if (i_cmd_valid && !o_cmd_done) begin
            wr_q    <= i_cmd_write;
            rd_q    <= !i_cmd_write;
            addr_q  <= i_cmd_addr;
            wdata_q <= i_cmd_wdata;
            state   <= RWDT_ACCESS;
          end
        end
        RWDT_ACCESS: begin
          state <= RWDT_WAIT;
        end
        RWDT_WAIT: begin
          o_cmd_done <= 1'b1;
          state      <= RWDT_IDLE;
        end
        default: begin
          state <= RWDT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_cmd_rdata <= '0;
    end else if (bus.rvalid) begin
      o_cmd_rdata <= bus.rdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_nmi <= 1'b0;
    end else begin
      o_nmi <= bus.runaway_nmi_request;
    end
  end

  assign bus.wr    = wr_q;
  assign bus.rd    = rd_q;
  assign bus.addr  = addr_q;
  assign bus.wdata = wdata_q;
endmodule : rwdt_cpu

/* File: tb/rwdt_checker.sv */
/* Assertions on the watchdog link signals.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module rwdt_checker import rwdt_pkg::*; (
  input wire logic              i_sys_clk,
  input wire logic              i_reset,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              rvalid,
  input wire logic              runaway_nmi_request
);
  logic [7:0]  mode_sh;
  logic        off;
  logic [31:0] since;
  wire key_clr = wr && addr == ADDR_KEY_CMD && wdata == KEY_CLEAR;
  wire key_off = wr && addr == ADDR_KEY_CMD && wdata == KEY_DISABLE;
  wire mode_wr = wr && addr == ADDR_MODE;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  sequence s_mode_rd;
    rd && addr == ADDR_MODE;
  endsequence
  sequence s_mode_ans;
    ##1 rvalid && rdata == mode_sh;
  endsequence
  // ----------
  // Shadow state
  // ----------
  // Sleep and stops only delay the tap, so a lower bound stays safe
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || key_clr) since <= 32'h0;
    else since <= since + 32'h1;
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) mode_sh <= 8'h80;
    else if (mode_wr) mode_sh <= wdata & 8'hE6;
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) off <= 1'b0;
    else if (mode_wr && wdata[7]) off <= 1'b0;
    else if (key_off && !mode_sh[7]) off <= 1'b1;
  end
  rd_answer_a: assert property (rd |=> rvalid)
    else $error("read strobe got no answer");
  rvalid_src_a: assert property (rvalid |-> $past(rd))
    else $error("answer without a read strobe");
  mode_read_a: assert property (s_mode_rd |-> s_mode_ans)
    else $error("mode register read back wrong");
  key_read_a: assert property (rd && addr == ADDR_KEY_CMD |=> rdata == 8'h00)
    else $error("key register read not zero");
  nmi_pulse_a: assert property (
    runaway_nmi_request |=> !runaway_nmi_request [*8])
    else $error("NMI request not a single pulse");
  nmi_time_a: assert property (
    runaway_nmi_request |-> since >= 32'h7FFE)
    else $error("NMI came before the shortest tap");
  clear_hold_a: assert property (key_clr |=> !runaway_nmi_request)
    else $error("NMI right after a clear key");
  off_quiet_a: assert property (
    off && $past(off) |-> !runaway_nmi_request)
    else $error("NMI while disabled");
endmodule : rwdt_checker

/* File: tb/runaway_watchdog_timer_tb_top.sv */
/* Bench: CPU end and device joined by the link interface, driven
   through the command port. Assumes a 20 MHz clock. */
`timescale 1ns/100ps
module runaway_watchdog_timer_tb_top;
  import rwdt_pkg::*;
  logic        clk, rst, light_sleep, full_stop, partial_sleep, bus_ack_n;
  logic        cmd_valid, cmd_write, cmd_done, nmi, int_rst;
  logic [15:0] cmd_addr;
  logic [7:0]  cmd_wdata, cmd_rdata;
  logic [7:0]  bad [3];
  logic [21:0] count;
  int          fail_count, comparisons, n;
  rwdt_if u_rwdt_if ();
  rwdt_device u_rwdt_device (.i_sys_clk(clk), .i_reset(rst),
    .bus(u_rwdt_if.device), .i_light_sleep_mode(light_sleep),
    .i_full_stop_mode(full_stop), .i_partial_sleep_mode(partial_sleep),
    .i_bus_release_ack_n(bus_ack_n), .o_internal_reset(int_rst),
    .o_count(count));
  rwdt_cpu u_rwdt_cpu (.i_sys_clk(clk), .i_reset(rst),
    .bus(u_rwdt_if.cpu), .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write),
    .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata),
    .o_cmd_rdata(cmd_rdata), .o_cmd_done(cmd_done), .o_nmi(nmi));
  rwdt_checker u_rwdt_checker (.i_sys_clk(clk), .i_reset(rst),
    .wr(u_rwdt_if.wr), .rd(u_rwdt_if.rd), .addr(u_rwdt_if.addr),
    .wdata(u_rwdt_if.wdata), .rdata(u_rwdt_if.rdata),
    .rvalid(u_rwdt_if.rvalid),
    .runaway_nmi_request(u_rwdt_if.runaway_nmi_request));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------
  // Tasks
  // ----------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  // Valid drops at the edge after done; the port skips that edge
  task automatic cmd(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    int i;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    for (i = 0; i < 10 && cmd_done !== 1'b1; i++) @(negedge clk);
    if (cmd_done !== 1'b1) begin
      fail_count++;
      final_report();
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask : cmd
  task automatic adv(input int k, input logic [21:0] delta);
    logic [21:0] c0;
    repeat (3) @(negedge clk);
    c0 = count;
    repeat (k) @(negedge clk);
    c0 = count - c0;
    check("counter advance", {10'h000, c0}, {10'h000, delta});
  endtask : adv
  task automatic stall(input logic [2:0] s, input logic [21:0] delta);
    @(posedge clk);
    {light_sleep, full_stop, partial_sleep} <= s;
    adv(10, delta);
    @(posedge clk);
    {light_sleep, full_stop, partial_sleep} <= 3'h0;
  endtask : stall
  // ----------
  // Main sequence
  // ----------
  initial begin
    {rst, light_sleep, full_stop, partial_sleep} = 4'h8;
    {bus_ack_n, cmd_valid, cmd_write} = 3'h4;
    cmd_addr = 16'h0000;
    cmd_wdata = 8'h00;
    bad = '{8'h00, KEY_DISABLE, 8'hFF};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cmd(1'b0, ADDR_MODE, 8'h00);
    check("mode reset", cmd_rdata, 8'h80);
    adv(10, 22'h00000A);
    foreach (bad[i]) begin
      repeat (40) @(negedge clk);
      cmd(1'b1, ADDR_KEY_CMD, bad[i]);
      check("count kept", count >= 22'h000028, 1'b1);
    end
    adv(10, 22'h00000A);
    cmd(1'b1, ADDR_KEY_CMD, KEY_CLEAR);
    check("count cleared", count < 22'h000008, 1'b1);
    adv(10, 22'h00000A);
    @(posedge clk);
    bus_ack_n <= 1'b0;
    adv(10, 22'h00000A);
    @(posedge clk);
    bus_ack_n <= 1'b1;
    stall(3'h4, 22'h000000);
    stall(3'h2, 22'h000000);
    stall(3'h1, 22'h000000);
    cmd(1'b1, ADDR_MODE, 8'h84);
    stall(3'h1, 22'h00000A);
    cmd(1'b1, ADDR_KEY_CMD, KEY_CLEAR);
    cmd(1'b1, ADDR_MODE, 8'h00);
    adv(10, 22'h00000A);
    cmd(1'b1, ADDR_KEY_CMD, KEY_DISABLE);
    adv(10, 22'h000000);
    cmd(1'b1, ADDR_MODE, 8'h82);
    adv(10, 22'h00000A);
    cmd(1'b1, ADDR_KEY_CMD, KEY_CLEAR);
    for (n = 0; n < 40000 && nmi !== 1'b1; n++) @(negedge clk);
    check("nmi delay", n >= 32764 && n <= 32770, 1'b1);
    if (nmi !== 1'b1) final_report();
    for (n = 0; n < 4 && int_rst !== 1'b1; n++) @(negedge clk);
    for (n = 0; n < 40 && int_rst === 1'b1; n++) @(negedge clk);
    check("forced reset", n >= 22 && n <= 29, 1'b1);
    cmd(1'b1, ADDR_MODE, 8'h00);
    cmd(1'b1, ADDR_KEY_CMD, KEY_DISABLE);
    cmd(1'b1, ADDR_MODE, 8'hA0);
    cmd(1'b1, ADDR_KEY_CMD, KEY_CLEAR);
    n = 0;
    repeat (33000) begin
      @(negedge clk);
      if (nmi !== 1'b0) n++;
    end
    check("longer tap", n, 0);
    final_report();
  end
endmodule : runaway_watchdog_timer_tb_top
